//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
  import vccl_pkg::*;
  localparam logic [31:0] INC = 32'h0008_0100;
  localparam logic [31:0] DEC = 32'h0008_0000;
  // Pages 0 and 9 are control pages, 2 is busy and invalid, 3 invalid, 4 of a bad type.
  localparam logic [31:0] MAP [10] = '{32'h0000_0001, 32'h0000_0201, 32'h0000_0202,
    32'h0000_0200, 32'h0000_0301, 32'h0000_0101, 32'h0000_0401, 32'h0000_0501,
    32'h0000_0601, 32'h0000_0001};
  logic        clk      = 1'b0;
  logic        sys_rst  = 1'b1;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        op_busy;
  logic        op_done;
  logic [31:0] rdat;
  logic [31:0] cnt0     = 32'h0;
  int          miscompares = 0;
  int          checked     = 0;

  always #2.5 clk = ~clk;

  vccl_leaf #(.PAGES(16), .CNT_W(32)) vccl_leaf_inst (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wb_cyc_i (wb_cyc_i),
    .wb_stb_i (wb_stb_i),
    .wb_we_i  (wb_we_i),
    .wb_adr_i (wb_adr_i),
    .wb_sel_i (wb_sel_i),
    .wb_dat_i (wb_dat_i),
    .wb_dat_o (wb_dat_o),
    .wb_ack_o (wb_ack_o),
    .op_busy  (op_busy),
    .op_done  (op_done)
  );

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] pa(input int i);
    return 32'h0001_0000 + (32'(i) << 12);
  endfunction : pa

  task automatic results();
    if (miscompares == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 50);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      miscompares++;
      results();
    end
  endtask : bus

  // Runs one leaf and checks status, fault address, flags, result and the page 0 counter.
  task automatic leaf(input logic [31:0] cmd, input logic [31:0] tgt, input logic [31:0] cp,
                      input logic [1:0] flt, input logic [31:0] exp, input int dlt);
    int n;
    bus(1'b1, OFS_TGT_LO, tgt);
    bus(1'b1, OFS_CP_LO, cp);
    bus(1'b1, OFS_FLAGS, 32'h0000_08d5);
    bus(1'b1, OFS_CTRL, cmd | 32'h0000_0001);
    n = 0;
    while (op_done !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (op_done !== 1'b1)
    begin
      miscompares++;
      results();
    end
    cnt0 = cnt0 + 32'(dlt);
    bus(1'b0, OFS_STATUS, 32'h0);
    chk({30'h0, rdat[3:2]}, {30'h0, flt});
    chk({30'h0, rdat[1:0]}, 32'h0000_0002);
    chk({31'h0, rdat[4]}, {31'h0, flt == 2'h2});
    if (flt == 2'h2)
    begin
      bus(1'b0, OFS_FAULT_LO, 32'h0);
      chk(rdat, exp);
    end
    bus(1'b0, OFS_FLAGS, 32'h0);
    chk(rdat, (flt != 2'h0) ? 32'h0000_08d5 : ((exp != 32'h0) ? 32'h0000_0040 : 32'h0));
    if (flt == 2'h0)
    begin
      bus(1'b0, OFS_RESULT, 32'h0);
      chk(rdat, exp);
    end
    bus(1'b0, OFS_COUNT, 32'h0);
    chk(rdat, cnt0);
  endtask : leaf

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    bus(1'b0, OFS_CTRL, 32'h0);
    chk(rdat, CTRL_RESET);
    bus(1'b1, 8'h40, 32'hffff_ffff);
    bus(1'b0, 8'h40, 32'h0);
    chk(rdat, 32'h0);
    bus(1'b1, OFS_CACHE_BASE, 32'h0001_0000);
    bus(1'b1, OFS_DS_LIMIT, 32'hffff_ffff);
    for (int i = 0; i < 10; i++)
    begin
      bus(1'b1, OFS_MAP_SEL, 32'(i));
      bus(1'b1, OFS_MAP_DATA, MAP[i]);
    end
    bus(1'b1, OFS_MAP_SEL, 32'h0);
    leaf(INC, pa(1), pa(0), 2'h0, ERR_NONE, 1);
    for (int i = 5; i < 9; i++)
      leaf(INC, pa(i), pa(0), 2'h0, ERR_NONE, 1);
    leaf(INC, pa(0), pa(0), 2'h0, ERR_NONE, 1);
    leaf(INC | 32'h0004_0000, pa(1), pa(0), 2'h0, ERR_NONE, 1);
    repeat (7) leaf(DEC, pa(1), pa(0), 2'h0, ERR_NONE, -1);
    leaf(DEC, pa(1), pa(0), 2'h0, counter_invalid_error, 0);
    leaf(DEC, pa(1) + 32'h4, pa(0), 2'h1, 32'h0, 0);
    leaf(DEC, pa(16), pa(20), 2'h2, pa(16), 0);
    leaf(INC, pa(1), pa(20), 2'h2, pa(20), 0);
    // Busy is checked before valid, so the invalid busy page still reports a conflict.
    leaf(INC, pa(2), pa(0), 2'h0, page_conflict_error, 0);
    leaf(INC, pa(3), pa(0), 2'h2, pa(3), 0);
    leaf(INC, pa(4), pa(0), 2'h2, pa(4), 0);
    leaf(INC, pa(1), pa(9), 2'h1, 32'h0, 0);
    leaf(INC | 32'h0003_0000, pa(1), pa(0), 2'h1, 32'h0, 0);
    leaf(INC | 32'h0010_0000, pa(1), pa(0), 2'h1, 32'h0, 0);
    leaf(32'h0000_0100, pa(1), pa(0), 2'h1, 32'h0, 0);
    leaf(32'h0008_0200, pa(1), pa(0), 2'h1, 32'h0, 0);
    // A nonzero segment base moves both operands; without it the control operand misses.
    bus(1'b1, OFS_DS_BASE, 32'h0000_1000);
    leaf(INC, pa(0), pa(0) - 32'h0000_1000, 2'h0, ERR_NONE, 1);
    bus(1'b1, OFS_DS_BASE, 32'h0);
    bus(1'b1, OFS_DS_LIMIT, pa(1) + 32'h0000_0ffe);
    leaf(INC, pa(1), pa(0), 2'h1, 32'h0, 0);
    bus(1'b1, OFS_DS_LIMIT, 32'hffff_ffff);
    bus(1'b1, OFS_TGT_HI, 32'h0001_0000);
    leaf(INC | 32'h0004_0000, pa(1), pa(0), 2'h1, 32'h0, 0);
    results();
  end
endmodule : testbench

//--- dv/vccl_leaf_sva.sv
`timescale 1ns/1ps
module vccl_leaf_sva
  import vccl_pkg::*;
#(
  parameter int PAGES = 16,
  parameter int CNT_W = 32
)(
  input wire logic                         clk,
  input wire logic                         sys_rst,
  input wire logic                         wb_cyc_i,
  input wire logic                         wb_stb_i,
  input wire logic                         wb_we_i,
  input wire logic [vccl_pkg::ADR_W-1:0]   wb_adr_i,
  input wire logic [3:0]                   wb_sel_i,
  input wire logic [31:0]                  wb_dat_i,
  input wire logic [31:0]                  wb_dat_o,
  input wire logic                         wb_ack_o,
  input wire logic                         op_busy,
  input wire logic                         op_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ////////////////////////////////////////////////////////////////////////////////
  logic start_w;

  // A start written while a leaf runs is ignored, so it is not a start here.
  assign start_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL
                   && wb_sel_i[0] && wb_dat_i[CTRL_START] && !op_busy;

  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  sequence s_start;
    start_w;
  endsequence

  sequence s_finish;
    ##[1:3] !op_busy;
  endsequence

  ////////////////////////////////////////////////////////////////////////////////
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("request not answered in one cycle");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
    else $error("read data driven without ack");
  a_start_busy: assert property (s_start |=> op_busy && !op_done)
    else $error("start did not launch a leaf");
  a_busy_bounded: assert property ($rose(op_busy) |-> s_finish)
    else $error("leaf ran longer than three cycles");
  a_done_at_end: assert property ($fell(op_busy) |-> op_done)
    else $error("leaf ended without done");
  a_done_holds: assert property (op_done && !start_w |=> op_done)
    else $error("done dropped without a new start");
  a_busy_excl: assert property (op_busy |-> !op_done)
    else $error("busy and done together");
endmodule : vccl_leaf_sva

bind vccl_leaf vccl_leaf_sva #(.PAGES(PAGES), .CNT_W(CNT_W)) vccl_leaf_sva_inst (
  .clk      (clk),
  .sys_rst  (sys_rst),
  .wb_cyc_i (wb_cyc_i),
  .wb_stb_i (wb_stb_i),
  .wb_we_i  (wb_we_i),
  .wb_adr_i (wb_adr_i),
  .wb_sel_i (wb_sel_i),
  .wb_dat_i (wb_dat_i),
  .wb_dat_o (wb_dat_o),
  .wb_ack_o (wb_ack_o),
  .op_busy  (op_busy),
  .op_done  (op_done)
);

//--- hdl/vccl_leaf.sv
`timescale 1ns/1ps
module vccl_leaf
  import vccl_pkg::*;
#(
  parameter int PAGES = 16,
  parameter int CNT_W = 32
)(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [vccl_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  output logic                      op_busy,
  output logic                      op_done
);
  import vccl_pkg::*;

  localparam int IDX_W = $clog2(PAGES);

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (sel[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [63:0] cache_off(input logic [63:0] a,
                                            input logic [31:0] base);
    return a - {32'h0, base};
  endfunction : cache_off

  function automatic logic in_cache(input logic [63:0] a,
                                    input logic [31:0] base);
    logic [63:0] off;
    off = cache_off(a, base);
    return (a >= {32'h0, base}) &&
           (off[63:PAGE_SHIFT] < (64 - PAGE_SHIFT)'(PAGES));
  endfunction : in_cache

  function automatic logic [IDX_W-1:0] page_idx(input logic [63:0] a,
                                                input logic [31:0] base);
    logic [63:0] off;
    off = cache_off(a, base);
    return off[PAGE_SHIFT +: IDX_W];
  endfunction : page_idx

  function automatic logic seg_bad(input logic [63:0] eff,
                                   input logic        m64,
                                   input logic        usable,
                                   input logic [31:0] limit);
    if (m64)
    begin
      return !((&eff[63:CANON_MSB]) || !(|eff[63:CANON_MSB]));
    end
    return !usable || (({1'b0, eff[31:0]} + PAGE_LAST) > {1'b0, limit});
  endfunction : seg_bad

  ////////////////////////////////////////////////////////////////////
  logic [31:0]      ctrl;
  logic [63:0]      tgt;
  logic [63:0]      cpo;
  logic [31:0]      ds_base;
  logic [31:0]      ds_limit;
  logic [31:0]      result;
  logic [31:0]      flags;
  logic [63:0]      fault_addr;
  vccl_fault_t      fault_kind;
  logic             fault_enc;
  logic [31:0]      cache_base;
  logic [IDX_W-1:0] map_sel;
  logic             map_valid  [PAGES];
  logic             map_busy   [PAGES];
  logic [7:0]       map_type   [PAGES];
  logic [IDX_W-1:0] map_parent [PAGES];
  logic [CNT_W-1:0] count      [PAGES];
  vccl_state_t      state;
  logic [IDX_W-1:0] upd_idx;
  logic             wb_req;
  logic             wb_wr;
  logic             start;
  logic [31:0]      rd_data;

  assign wb_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr   = wb_req && wb_we_i;
  assign start   = wb_wr && (wb_adr_i == OFS_CTRL) && wb_sel_i[0] &&
                   wb_dat_i[CTRL_START] && (state == ST_IDLE);
  assign op_busy = (state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////
  // Software setup. Operands and page map freeze while a leaf runs so
  // the counter update stays atomic against bus traffic.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ctrl       <= CTRL_RESET;
      tgt        <= '0;
      cpo        <= '0;
      ds_base    <= '0;
      ds_limit   <= '0;
      cache_base <= '0;
      map_sel    <= '0;
    end
    else if (wb_wr && state == ST_IDLE)
    begin
      case (wb_adr_i)
        OFS_CTRL:       ctrl       <= merge(ctrl, wb_dat_i, wb_sel_i);
        OFS_TGT_LO:     tgt[31:0]  <= merge(tgt[31:0], wb_dat_i, wb_sel_i);
        OFS_TGT_HI:     tgt[63:32] <= merge(tgt[63:32], wb_dat_i, wb_sel_i);
        OFS_CP_LO:      cpo[31:0]  <= merge(cpo[31:0], wb_dat_i, wb_sel_i);
        OFS_CP_HI:      cpo[63:32] <= merge(cpo[63:32], wb_dat_i, wb_sel_i);
        OFS_DS_BASE:    ds_base    <= merge(ds_base, wb_dat_i, wb_sel_i);
        OFS_DS_LIMIT:   ds_limit   <= merge(ds_limit, wb_dat_i, wb_sel_i);
        OFS_CACHE_BASE: cache_base <= merge(cache_base, wb_dat_i, wb_sel_i);
        OFS_MAP_SEL:    map_sel    <= wb_dat_i[IDX_W-1:0];
        default:        ;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < PAGES; i++)
      begin
        map_valid[i]  <= 1'b0;
        map_busy[i]   <= 1'b0;
        map_type[i]   <= '0;
        map_parent[i] <= '0;
      end
    end
    else if (wb_wr && state == ST_IDLE && wb_adr_i == OFS_MAP_DATA)
    begin
      map_valid[map_sel]  <= wb_dat_i[MAP_VALID];
      map_busy[map_sel]   <= wb_dat_i[MAP_BUSY];
      map_type[map_sel]   <= wb_dat_i[MAP_TYPE_LSB +: 8];
      map_parent[map_sel] <= wb_dat_i[MAP_PARENT_LSB +: IDX_W];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Operand checks, evaluated from the frozen operands.
  logic             m64;
  logic [63:0]      t_lin;
  logic [63:0]      c_lin;
  logic [IDX_W-1:0] t_idx;
  logic [IDX_W-1:0] c_idx;
  logic [7:0]       leaf;
  logic [7:0]       t_type;
  vccl_fault_t      chk_fault;
  logic [63:0]      chk_addr;
  logic             chk_conflict;
  logic [IDX_W-1:0] chk_sel;

  assign m64    = ctrl[CTRL_MODE64];
  assign leaf   = ctrl[CTRL_LEAF_LSB +: 8];
  // Linear address uses the data segment base only; long mode has none.
  assign t_lin  = m64 ? tgt : {32'h0, ds_base + tgt[31:0]};
  assign c_lin  = m64 ? cpo : {32'h0, ds_base + cpo[31:0]};
  assign t_idx  = page_idx(t_lin, cache_base);
  assign c_idx  = page_idx(c_lin, cache_base);
  assign t_type = map_type[t_idx];

  // Checks in strict order; the first failure decides.
  always_comb
  begin
    chk_fault    = FAULT_NONE;
    chk_addr     = '0;
    chk_conflict = 1'b0;
    chk_sel      = '0;
    if (ctrl[CTRL_CPL_LSB +: 2] != CPL_KERNEL)
    begin
      chk_fault = FAULT_GP;
    end
    else if (ctrl[CTRL_SEG_OVR])
    begin
      chk_fault = FAULT_GP;
    end
    else if (leaf != LEAF_DEC && leaf != LEAF_INC)
    begin
      chk_fault = FAULT_GP;
    end
    else if (tgt[PAGE_SHIFT-1:0] != '0)
    begin
      chk_fault = FAULT_GP;
    end
    else if (seg_bad(tgt, m64, ctrl[CTRL_DS_USABLE], ds_limit) ||
             seg_bad(cpo, m64, ctrl[CTRL_DS_USABLE], ds_limit))
    begin
      chk_fault = FAULT_GP;
    end
    else if (!in_cache(t_lin, cache_base))
    begin
      chk_fault = FAULT_PF;
      chk_addr  = t_lin;
    end
    else if (!in_cache(c_lin, cache_base))
    begin
      chk_fault = FAULT_PF;
      chk_addr  = c_lin;
    end
    else if (map_busy[t_idx])
    begin
      chk_conflict = 1'b1;
    end
    else if (!map_valid[t_idx])
    begin
      chk_fault = FAULT_PF;
      chk_addr  = t_lin;
    end
    else if (t_type == regular_page_type || t_type == thread_control_page_type ||
             t_type == trimmed_page_type || t_type == first_shadow_stack_type ||
             t_type == later_shadow_stack_type)
    begin
      chk_sel = map_parent[t_idx];
    end
    else if (t_type == control_page_type)
    begin
      chk_sel = t_idx;
    end
    else
    begin
      chk_fault = FAULT_PF;
      chk_addr  = t_lin;
    end
    if (chk_fault == FAULT_NONE && !chk_conflict && chk_sel != c_idx)
    begin
      chk_fault = FAULT_GP;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Leaf sequencer. Faults leave flags and result untouched.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state      <= ST_IDLE;
      upd_idx    <= '0;
      result     <= ERR_NONE;
      fault_kind <= FAULT_NONE;
      fault_addr <= '0;
      fault_enc  <= 1'b0;
      op_done    <= 1'b0;
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          if (start)
          begin
            state      <= ST_CHECK;
            op_done    <= 1'b0;
            fault_kind <= FAULT_NONE;
            fault_enc  <= 1'b0;
            fault_addr <= '0;
          end
        end
        ST_CHECK:
        begin
          if (chk_fault != FAULT_NONE)
          begin
            fault_kind <= chk_fault;
            fault_enc  <= (chk_fault == FAULT_PF);
            fault_addr <= chk_addr;
            op_done    <= 1'b1;
            state      <= ST_IDLE;
          end
          else if (chk_conflict)
          begin
            result  <= page_conflict_error;
            op_done <= 1'b1;
            state   <= ST_IDLE;
          end
          else
          begin
            upd_idx <= chk_sel;
            state   <= ST_UPDATE;
          end
        end
        ST_UPDATE:
        begin
          if (leaf == LEAF_DEC && count[upd_idx] == '0)
          begin
            state <= ST_RESTORE;
          end
          else
          begin
            result  <= ERR_NONE;
            op_done <= 1'b1;
            state   <= ST_IDLE;
          end
        end
        ST_RESTORE:
        begin
          result  <= counter_invalid_error;
          op_done <= 1'b1;
          state   <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Counters change only here; the bus path is locked out while busy,
  // which keeps each update locked; a zero counter decrement wraps, then ST_RESTORE adds 1 back.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < PAGES; i++)
      begin
        count[i] <= '0;
      end
    end
    else if (state == ST_UPDATE)
    begin
      if (leaf == LEAF_DEC)
      begin
        count[upd_idx] <= count[upd_idx] - CNT_W'(1);
      end
      else
      begin
        count[upd_idx] <= count[upd_idx] + CNT_W'(1);
      end
    end
    else if (state == ST_RESTORE)
    begin
      count[upd_idx] <= count[upd_idx] + CNT_W'(1);
    end
    else if (wb_wr && state == ST_IDLE && wb_adr_i == OFS_COUNT)
    begin
      count[map_sel] <= wb_dat_i[CNT_W-1:0];
    end
  end

  // The sequencer's flag update wins over a same-cycle software write.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      flags <= FLAGS_RESET;
    end
    else if ((state == ST_CHECK && chk_fault == FAULT_NONE) ||
             state == ST_UPDATE || state == ST_RESTORE)
    begin
      if (state != ST_UPDATE || leaf != LEAF_DEC || count[upd_idx] != '0)
      begin
        flags[FL_CF] <= 1'b0;
        flags[FL_PF] <= 1'b0;
        flags[FL_AF] <= 1'b0;
        flags[FL_OF] <= 1'b0;
        flags[FL_SF] <= 1'b0;
        flags[FL_ZF] <= (state != ST_UPDATE);
      end
    end
    else if (wb_wr && wb_adr_i == OFS_FLAGS)
    begin
      flags <= merge(flags, wb_dat_i, wb_sel_i);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Bus read path; unmapped offsets read zero and still acknowledge.
  always_comb
  begin
    rd_data = '0;
    case (wb_adr_i)
      OFS_CTRL:       rd_data = ctrl;
      OFS_TGT_LO:     rd_data = tgt[31:0];
      OFS_TGT_HI:     rd_data = tgt[63:32];
      OFS_CP_LO:      rd_data = cpo[31:0];
      OFS_CP_HI:      rd_data = cpo[63:32];
      OFS_DS_BASE:    rd_data = ds_base;
      OFS_DS_LIMIT:   rd_data = ds_limit;
      OFS_RESULT:     rd_data = result;
      OFS_STATUS:
      begin
        rd_data[ST_BUSY]             = op_busy;
        rd_data[ST_DONE]             = op_done;
        rd_data[ST_FAULT_LSB +: 2]   = fault_kind;
        rd_data[ST_ENC_FAULT]        = fault_enc;
      end
      OFS_FLAGS:      rd_data = flags;
      OFS_FAULT_LO:   rd_data = fault_addr[31:0];
      OFS_FAULT_HI:   rd_data = fault_addr[63:32];
      OFS_CACHE_BASE: rd_data = cache_base;
      OFS_MAP_SEL:    rd_data[IDX_W-1:0] = map_sel;
      OFS_MAP_DATA:
      begin
        rd_data[MAP_VALID]                = map_valid[map_sel];
        rd_data[MAP_BUSY]                 = map_busy[map_sel];
        rd_data[MAP_TYPE_LSB +: 8]        = map_type[map_sel];
        rd_data[MAP_PARENT_LSB +: IDX_W]  = map_parent[map_sel];
      end
      OFS_COUNT:      rd_data[CNT_W-1:0] = count[map_sel];
      default:        rd_data = '0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end
    else
    begin
      wb_ack_o <= wb_req;
      wb_dat_o <= (wb_req && !wb_we_i) ? rd_data : '0;
    end
  end
endmodule : vccl_leaf

//--- hdl/vccl_pkg.sv
package vccl_pkg;
  localparam int          ADR_W          = 8;
  localparam logic [7:0]  OFS_CTRL       = 8'h00;
  localparam logic [7:0]  OFS_TGT_LO     = 8'h04;
  localparam logic [7:0]  OFS_TGT_HI     = 8'h08;
  localparam logic [7:0]  OFS_CP_LO      = 8'h0c;
  localparam logic [7:0]  OFS_CP_HI      = 8'h10;
  localparam logic [7:0]  OFS_DS_BASE    = 8'h14;
  localparam logic [7:0]  OFS_DS_LIMIT   = 8'h18;
  localparam logic [7:0]  OFS_RESULT     = 8'h1c;
  localparam logic [7:0]  OFS_STATUS     = 8'h20;
  localparam logic [7:0]  OFS_FLAGS      = 8'h24;
  localparam logic [7:0]  OFS_FAULT_LO   = 8'h28;
  localparam logic [7:0]  OFS_FAULT_HI   = 8'h2c;
  localparam logic [7:0]  OFS_CACHE_BASE = 8'h30;
  localparam logic [7:0]  OFS_MAP_SEL    = 8'h34;
  localparam logic [7:0]  OFS_MAP_DATA   = 8'h38;
  localparam logic [7:0]  OFS_COUNT      = 8'h3c;
  // Control register fields.
  localparam int          CTRL_START     = 0;
  localparam int          CTRL_LEAF_LSB  = 8;
  localparam int          CTRL_CPL_LSB   = 16;
  localparam int          CTRL_MODE64    = 18;
  localparam int          CTRL_DS_USABLE = 19;
  localparam int          CTRL_SEG_OVR   = 20;
  localparam logic [31:0] CTRL_RESET     = 32'h0008_0000;
  localparam logic [7:0]  LEAF_DEC       = 8'h00;
  localparam logic [7:0]  LEAF_INC       = 8'h01;
  localparam logic [1:0]  CPL_KERNEL     = 2'h0;
  // Page geometry and address form.
  localparam int          PAGE_SHIFT     = 12;
  localparam int          CANON_MSB      = 47;
  localparam logic [32:0] PAGE_LAST      = 33'h0_0000_0fff;
  // Page map entry fields.
  localparam int          MAP_VALID      = 0;
  localparam int          MAP_BUSY       = 1;
  localparam int          MAP_TYPE_LSB   = 8;
  localparam int          MAP_PARENT_LSB = 16;
  // Page types.
  localparam logic [7:0]  control_page_type        = 8'h00;
  localparam logic [7:0]  thread_control_page_type = 8'h01;
  localparam logic [7:0]  regular_page_type        = 8'h02;
  localparam logic [7:0]  trimmed_page_type        = 8'h04;
  localparam logic [7:0]  first_shadow_stack_type  = 8'h05;
  localparam logic [7:0]  later_shadow_stack_type  = 8'h06;
  // Status fields and flag positions.
  localparam int          ST_BUSY        = 0;
  localparam int          ST_DONE        = 1;
  localparam int          ST_FAULT_LSB   = 2;
  localparam int          ST_ENC_FAULT   = 4;
  localparam int          FL_CF          = 0;
  localparam int          FL_PF          = 2;
  localparam int          FL_AF          = 4;
  localparam int          FL_ZF          = 6;
  localparam int          FL_SF          = 7;
  localparam int          FL_OF          = 11;
  localparam logic [31:0] FLAGS_RESET    = 32'h0000_0000;
  localparam logic [31:0] ERR_NONE       = 32'h0000_0000;
  localparam logic [31:0] page_conflict_error   = 32'h0000_0001;
  localparam logic [31:0] counter_invalid_error = 32'h0000_0002;
  typedef enum logic [1:0] {FAULT_NONE, FAULT_GP, FAULT_PF} vccl_fault_t;
  typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_UPDATE, ST_RESTORE} vccl_state_t;
endpackage : vccl_pkg
